// ---- hdl/axc_pkg.sv ----
// constants shared by the axis counter front end
package axc_pkg;
	// register byte offsets on the wishbone bus
	localparam logic [7:0] OFS_INPUT_ENV  = 8'h00;
	localparam logic [7:0] OFS_SOURCE_ENV = 8'h04;
	localparam logic [7:0] OFS_ERR_CAUSE  = 8'h08;
	localparam logic [7:0] OFS_TARGET     = 8'h0C;
	localparam logic [7:0] OFS_OPMODE     = 8'h10;
	localparam logic [7:0] OFS_COMMAND    = 8'h14;
	localparam logic [7:0] OFS_CMD_CNT    = 8'h18;
	localparam logic [7:0] OFS_MECH_CNT   = 8'h1C;
	localparam logic [7:0] OFS_DEFL_CNT   = 8'h20;
	localparam logic [7:0] OFS_GEN_CNT    = 8'h24;
	localparam logic [7:0] OFS_POS_CNT    = 8'h28;
	// counter_input_env fields
	localparam int ENC_FILT_BIT = 18;
	localparam int PUL_FILT_BIT = 19;
	localparam int ENC_MODE_LO  = 20;
	localparam int ENC_DIR_BIT  = 22;
	localparam int PUL_MODE_LO  = 24;
	localparam int PUL_DIR_BIT  = 26;
	localparam int ENC_OFF_BIT  = 30;
	localparam int PUL_OFF_BIT  = 31;
	// counter_source_env fields
	localparam int MECH_SRC_LO  = 8;
	localparam int DEFL_SRC_LO  = 10;
	localparam int GEN_SRC_LO   = 12;
	// operation_mode_reg and command fields
	localparam int HOLD_EN_BIT  = 14;
	localparam int CMD_START    = 0;
	localparam int CMD_OVR2     = 1;
	// error_cause fields
	localparam int ERR_ENC_BIT  = 16;
	localparam int ERR_PUL_BIT  = 17;
	// widths and reset values
	localparam int CNT_W  = 28;
	localparam int DEFL_W = 16;
	localparam logic [31:0] ENV_RST = 32'h0000_0000;
	// glitch filter: pulses shorter than this many cycles are dropped
	localparam logic [1:0] FILT_CYC = 2'h3;
	// decoder modes
	typedef enum logic [1:0] {
		AXC_QUAD1 = 2'b00,
		AXC_QUAD2 = 2'b01,
		AXC_QUAD4 = 2'b10,
		AXC_UPDN  = 2'b11
	} axc_mode_t;
endpackage

// ---- hdl/axc_pin_filter.sv ----
// two-flop synchroniser with optional three-cycle glitch filter
`timescale 1ns/1ns
module axc_pin_filter import axc_pkg::*; (
	input  wire logic clk_i,     // reference clock
	input  wire logic rst_i,     // sync reset, high
	input  wire logic pin_i,     // raw pin level
	input  wire logic filt_en_i, // filter on
	output logic      lvl_o      // clean level
);
	logic       s1;  // first sync flop, read only by s2
	logic       s2;  // synchronised level
	logic [1:0] cnt; // cycles the new level has stood

	// synchroniser
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
		end else begin
			s1 <= pin_i;
			s2 <= s1;
		end
	end

	// accept a new level only once it has stood long enough
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt   <= 2'h0;
			lvl_o <= 1'b0;
		end else if (!filt_en_i || s2 == lvl_o) begin
			cnt   <= 2'h0;
			lvl_o <= s2;
		end else if (cnt == FILT_CYC - 2'h1) begin
			cnt   <= 2'h0;
			lvl_o <= s2;
		end else begin
			cnt <= cnt + 2'h1;
		end
	end

	// a filtered change needs three equal synchronised samples
	filt_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		filt_en_i && $past(filt_en_i) && lvl_o != $past(lvl_o)
		|-> $past(s2) == lvl_o && $past(s2, 2) == lvl_o && $past(s2, 3) == lvl_o)
		else $error("filtered level changed on a short pulse");
endmodule

// ---- hdl/axc_decoder.sv ----
// quadrature or up/down pulse decoder with simultaneous-edge error
`timescale 1ns/1ns
module axc_decoder import axc_pkg::*; (
	input  wire logic       clk_i,  // reference clock
	input  wire logic       rst_i,  // sync reset, high
	input  wire logic       a_i,    // clean phase a
	input  wire logic       b_i,    // clean phase b
	input  wire logic [1:0] mode_i, // decode mode
	input  wire logic       rev_i,  // reverse direction
	input  wire logic       off_i,  // ignore a and b
	output logic            up_o,   // count up pulse
	output logic            dn_o,   // count down pulse
	output logic            err_o   // both phases changed pulse
);
	logic pa, pb, primed;     // previous levels, first sample taken
	logic a, b, qa, qb;       // swapped current and previous
	logic ar, af, br, bf;     // edges
	logic next_up, next_dn;

	// reversing swaps the phases; prev is kept raw so a swap makes no edge
	assign a  = rev_i ? b_i : a_i;
	assign b  = rev_i ? a_i : b_i;
	assign qa = rev_i ? pb : pa;
	assign qb = rev_i ? pa : pb;
	assign ar = a & ~qa;
	assign af = ~a & qa;
	assign br = b & ~qb;
	assign bf = ~b & qb;

	// direction table per mode
	always_comb begin
		next_up = 1'b0;
		next_dn = 1'b0;
		unique case (axc_mode_t'(mode_i))
			AXC_QUAD1: begin
				next_up = ar & ~b;
				next_dn = af & ~b;
			end
			AXC_QUAD2: begin
				next_up = (ar & ~b) | (af & b);
				next_dn = (ar & b) | (af & ~b);
			end
			AXC_QUAD4: begin
				next_up = (ar & ~b) | (af & b) | (br & a) | (bf & ~a);
				next_dn = (ar & b) | (af & ~b) | (br & ~a) | (bf & a);
			end
			AXC_UPDN: begin
				next_up = ar;
				next_dn = bf;
			end
		endcase
	end

	// edge history, no edge reported before the first sample
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pa     <= 1'b0;
			pb     <= 1'b0;
			primed <= 1'b0;
		end else begin
			pa     <= a_i;
			pb     <= b_i;
			primed <= 1'b1;
		end
	end

	// registered count and error pulses; a double change counts nothing
	always_ff @(posedge clk_i) begin
		if (rst_i || !primed || off_i) begin
			up_o  <= 1'b0;
			dn_o  <= 1'b0;
			err_o <= 1'b0;
		end else begin
			err_o <= (ar | af) & (br | bf);
			up_o  <= next_up & ~((ar | af) & (br | bf));
			dn_o  <= next_dn & ~((ar | af) & (br | bf));
		end
	end

	// A leading counts up in 4x
	quad_up_a: assert property (@(posedge clk_i) disable iff (rst_i)
		primed && !off_i && mode_i == 2'b10 && !rev_i && ar && !b && !br && !bf
		|=> up_o && !dn_o)
		else $error("4x decode missed an up count");
	// reversal makes a leading b count up
	quad_rev_a: assert property (@(posedge clk_i) disable iff (rst_i)
		primed && !off_i && mode_i == 2'b00 && rev_i && b_i && !$past(b_i) && !a_i
		&& a_i == pa |=> up_o && !dn_o)
		else $error("reversed decode did not count up");
	// disabled inputs give no pulses
	dec_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		off_i |=> !up_o && !dn_o && !err_o)
		else $error("disabled decoder still counts");
endmodule

// ---- hdl/axc_counter_front.sv ----
// per-axis counter front end: positioning counter and four counters
//
// What this block does
// - start loads target, output pulses decrement it
// - override hold freezes positioning until trigger
// - command counter counts output pulses, widths fixed
// - mechanical counter source from bits 8-9
// - deflection counter compares two chosen sources
// - general counter source, includes half clock
// - quadrature: A leads up, B leads down
// - two-pulse: A rise up, B fall down
// - encoder decode mode from bits 20-21
// - pulser decode mode from bits 24-25
// - encoder direction bit 22 reverses counting
// - pulser direction bit 26 reverses counting
// - encoder filter drops pulses under 3 cycles
// - pulser filter drops pulses under 3 cycles
// - bit 30 disables encoder A/B, index stays
// - bit 31 disables pulser A/B
// - simultaneous change flags error bits 16, 17
// - pulser counts use scaled internal pulses
`timescale 1ns/1ns
module axc_counter_front import axc_pkg::*; (
	input  wire logic        clk_i,         // reference clock
	input  wire logic        rst_i,         // sync reset, high
	input  wire logic        cyc_i,         // wishbone cycle
	input  wire logic        stb_i,         // wishbone strobe
	input  wire logic        we_i,          // wishbone write
	input  wire logic [7:0]  adr_i,         // wishbone byte address
	input  wire logic [3:0]  sel_i,         // wishbone byte lanes
	input  wire logic [31:0] dat_i,         // wishbone write data
	output logic      [31:0] dat_o,         // wishbone read data
	output logic             ack_o,         // wishbone ack
	input  wire logic        enc_phase_a_i, // encoder A pin
	input  wire logic        enc_phase_b_i, // encoder B pin
	input  wire logic        enc_index_i,   // encoder index pin
	input  wire logic        manual_gen_a_i, // pulser A pin
	input  wire logic        manual_gen_b_i, // pulser B pin
	input  wire logic        override_trigger_input_i, // trigger pin
	input  wire logic        out_pulse_i,   // own output pulse
	input  wire logic        out_dir_i,     // own pulse direction, 1 minus
	input  wire logic        scaled_up_i,   // scaled pulser up pulse
	input  wire logic        scaled_dn_i,   // scaled pulser down pulse
	output logic             pulser_up_o,   // raw decoded pulser up
	output logic             pulser_dn_o,   // raw decoded pulser down
	output logic             enc_index_o    // filtered index level
);
	// register storage
	logic [31:0]       input_env;   // counter_input_env
	logic [31:0]       source_env;  // counter_source_env
	logic [31:0]       error_cause; // sticky error causes
	logic [CNT_W-1:0]  target;      // target position
	logic [31:0]       opmode;      // operation mode
	logic [CNT_W-1:0]  pos_cnt;     // positioning counter
	logic [CNT_W-1:0]  cmd_cnt;     // command position counter
	logic [CNT_W-1:0]  mech_cnt;    // mechanical position counter
	logic [DEFL_W-1:0] defl_cnt;    // deflection counter
	logic [CNT_W-1:0]  gen_cnt;     // general-purpose counter
	logic              hold;        // positioning frozen
	logic              half_clk;    // reference clock over two
	// clean pins and decoded events
	logic [5:0] raw, clean, filt;
	logic       enc_up, enc_dn, enc_err, pul_err;
	logic [1:0] ev_out, ev_enc, ev_pul, ev_half;
	logic [1:0] d_mech, d_gen, d_def1, d_def2;
	logic       trig_q;             // previous trigger level
	// bus decode
	logic       req, wr, rd_ack;
	logic [31:0] rdata;

	// rebuild a word honouring byte lanes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// source select, code per table; absent sources pass none
	function automatic logic [1:0] pick(input logic [1:0] code,
		input logic [1:0] e0, input logic [1:0] e1,
		input logic [1:0] e2, input logic [1:0] e3);
		logic [1:0] r;
		r = 2'b00;
		unique case (code)
			2'b00: r = e0;
			2'b01: r = e1;
			2'b10: r = e2;
			2'b11: r = e3;
		endcase
		return r;
	endfunction

	// {up,dn} pair to a signed step, sign-extended to w bits
	function automatic logic [CNT_W-1:0] step(input logic [1:0] ev);
		logic [CNT_W-1:0] r;
		r = '0;
		if (ev == 2'b10) begin
			r = 28'h000_0001;
		end else if (ev == 2'b01) begin
			r = 28'hFFF_FFFF;
		end
		return r;
	endfunction

	// pins: encoder A, B, index, pulser A, B, trigger
	assign raw = {override_trigger_input_i, manual_gen_b_i, manual_gen_a_i,
		enc_index_i, enc_phase_b_i, enc_phase_a_i};
	assign filt[2:0] = {3{input_env[ENC_FILT_BIT]}};
	assign filt[4:3] = {2{input_env[PUL_FILT_BIT]}};
	assign filt[5]   = 1'b0;

	// one synchroniser and filter per pin
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_pin
			axc_pin_filter u_pin (
				.clk_i     (clk_i),
				.rst_i     (rst_i),
				.pin_i     (raw[gi]),
				.filt_en_i (filt[gi]),
				.lvl_o     (clean[gi])
			);
		end
	endgenerate

	axc_decoder u_enc (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.a_i    (clean[0]),
		.b_i    (clean[1]),
		.mode_i (input_env[ENC_MODE_LO +: 2]),
		.rev_i  (input_env[ENC_DIR_BIT]),
		.off_i  (input_env[ENC_OFF_BIT]),
		.up_o   (enc_up),
		.dn_o   (enc_dn),
		.err_o  (enc_err)
	);

	axc_decoder u_pul (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.a_i    (clean[3]),
		.b_i    (clean[4]),
		.mode_i (input_env[PUL_MODE_LO +: 2]),
		.rev_i  (input_env[PUL_DIR_BIT]),
		.off_i  (input_env[PUL_OFF_BIT]),
		.up_o   (pulser_up_o),
		.dn_o   (pulser_dn_o),
		.err_o  (pul_err)
	);

	// index is not gated by the encoder disable bit
	assign enc_index_o = clean[2];

	// event pairs {up,dn}
	assign ev_out  = {out_pulse_i & ~out_dir_i, out_pulse_i & out_dir_i};
	assign ev_enc  = {enc_up, enc_dn};
	// counters see the scaled pulser stream, not the pins
	assign ev_pul  = {scaled_up_i, scaled_dn_i};
	assign ev_half = {half_clk, 1'b0};

	// mechanical source; code 11 counts nothing
	assign d_mech = pick(source_env[MECH_SRC_LO +: 2], ev_enc, ev_out, ev_pul, 2'b00);
	assign d_gen  = pick(source_env[GEN_SRC_LO +: 2], ev_out, ev_enc, ev_pul, ev_half);
	assign d_def1 = pick(source_env[DEFL_SRC_LO +: 2], ev_out, ev_out, ev_enc, 2'b00);
	assign d_def2 = pick(source_env[DEFL_SRC_LO +: 2], ev_enc, ev_pul, ev_pul, 2'b00);

	// bus request, writes land on the edge that raises ack
	assign req = cyc_i & stb_i & ~ack_o;
	assign wr  = req & we_i;

	// ack one cycle after request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= req;
			dat_o <= (req && !we_i) ? rdata : 32'h0000_0000;
		end
	end
	assign rd_ack = ack_o & ~we_i;

	// read map; write-only registers and holes read zero
	always_comb begin
		rdata = 32'h0000_0000;
		unique case (adr_i)
			OFS_ERR_CAUSE: rdata = error_cause;
			OFS_CMD_CNT:   rdata = {4'h0, cmd_cnt};
			OFS_MECH_CNT:  rdata = {4'h0, mech_cnt};
			OFS_DEFL_CNT:  rdata = {16'h0000, defl_cnt};
			OFS_GEN_CNT:   rdata = {4'h0, gen_cnt};
			OFS_POS_CNT:   rdata = {4'h0, pos_cnt};
			default:       rdata = 32'h0000_0000;
		endcase
	end

	// configuration registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			input_env  <= ENV_RST;
			source_env <= ENV_RST;
			opmode     <= ENV_RST;
			target     <= '0;
		end else if (wr) begin
			if (adr_i == OFS_INPUT_ENV) begin
				input_env <= merge(input_env, dat_i, sel_i);
			end
			if (adr_i == OFS_SOURCE_ENV) begin
				source_env <= merge(source_env, dat_i, sel_i);
			end
			if (adr_i == OFS_OPMODE) begin
				opmode <= merge(opmode, dat_i, sel_i);
			end
			if (adr_i == OFS_TARGET) begin
				target <= CNT_W'(merge({4'h0, target}, dat_i, sel_i));
			end
		end
	end

	// error causes: write one to clear, a new error wins over the clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			error_cause <= 32'h0000_0000;
		end else begin
			if (wr && adr_i == OFS_ERR_CAUSE) begin
				error_cause <= error_cause & ~merge(32'h0000_0000, dat_i, sel_i);
			end
			if (enc_err) begin
				error_cause[ERR_ENC_BIT] <= 1'b1;
			end
			if (pul_err) begin
				error_cause[ERR_PUL_BIT] <= 1'b1;
			end
		end
	end

	// half reference clock as an every-other-cycle pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			half_clk <= 1'b0;
		end else begin
			half_clk <= ~half_clk;
		end
	end

	// override hold: armed by override 2, released when trigger turns on
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold   <= 1'b0;
			trig_q <= 1'b0;
		end else begin
			trig_q <= clean[5];
			// arm on override 2 with hold enabled, free on trigger
			if (wr && adr_i == OFS_COMMAND && dat_i[CMD_OVR2] && sel_i[0]
				&& opmode[HOLD_EN_BIT]) begin
				hold <= 1'b1;
			end else if (clean[5] && !trig_q) begin
				hold <= 1'b0;
			end
		end
	end

	// positioning counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pos_cnt <= '0;
		end else if (wr && adr_i == OFS_COMMAND && dat_i[CMD_START] && sel_i[0]) begin
			// load the target at every start
			pos_cnt <= target;
		end else if (out_pulse_i && !hold) begin
			pos_cnt <= pos_cnt - 28'h000_0001;
		end
	end

	// command position counter, fed only by output pulses
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_cnt <= '0;
		end else if (wr && adr_i == OFS_CMD_CNT) begin
			cmd_cnt <= CNT_W'(merge({4'h0, cmd_cnt}, dat_i, sel_i));
		end else begin
			cmd_cnt <= cmd_cnt + step(ev_out);
		end
	end

	// mechanical position counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mech_cnt <= '0;
		end else if (wr && adr_i == OFS_MECH_CNT) begin
			mech_cnt <= CNT_W'(merge({4'h0, mech_cnt}, dat_i, sel_i));
		end else begin
			mech_cnt <= mech_cnt + step(d_mech);
		end
	end

	// deflection counter: first source minus second, 16 bits wraps
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			defl_cnt <= '0;
		end else if (wr && adr_i == OFS_DEFL_CNT) begin
			defl_cnt <= DEFL_W'(merge({16'h0000, defl_cnt}, dat_i, sel_i));
		end else begin
			defl_cnt <= defl_cnt + DEFL_W'(step(d_def1))
				- DEFL_W'(step(d_def2));
		end
	end

	// general-purpose counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gen_cnt <= '0;
		end else if (wr && adr_i == OFS_GEN_CNT) begin
			gen_cnt <= CNT_W'(merge({4'h0, gen_cnt}, dat_i, sel_i));
		end else begin
			gen_cnt <= gen_cnt + step(d_gen);
		end
	end

	// start loads the target
	pos_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && adr_i == OFS_COMMAND && dat_i[0] && sel_i[0]
		|=> pos_cnt == $past(target))
		else $error("start did not load the target");
	// each free output pulse takes one off
	pos_dec_a: assert property (@(posedge clk_i) disable iff (rst_i)
		out_pulse_i && !hold && !(wr && adr_i == OFS_COMMAND)
		|=> pos_cnt == $past(pos_cnt) - 28'h000_0001)
		else $error("positioning counter missed a pulse");
	// held counter stays put
	pos_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		hold && !(wr && adr_i == OFS_COMMAND) |=> $stable(pos_cnt))
		else $error("positioning counter moved while held");
	// command counter ignores everything but own pulses
	cmd_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!out_pulse_i && !(wr && adr_i == OFS_CMD_CNT) |=> $stable(cmd_cnt))
		else $error("command counter moved without output pulse");
	// mechanical counter follows output pulses on code 01
	mech_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
		source_env[9:8] == 2'b01 && out_pulse_i && !out_dir_i
		&& !(wr && adr_i == OFS_MECH_CNT)
		|=> mech_cnt == $past(mech_cnt) + 28'h000_0001)
		else $error("mechanical counter missed an output pulse");
	// half clock source counts every second cycle
	gen_half_a: assert property (@(posedge clk_i) disable iff (rst_i)
		source_env[13:12] == 2'b11 && !wr ##1 source_env[13:12] == 2'b11 && !wr
		|=> gen_cnt == $past(gen_cnt, 2) + 28'h000_0001)
		else $error("half clock rate wrong");
	// encoder error lands in the cause register
	enc_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
		enc_err |=> error_cause[16])
		else $error("encoder error not recorded");
	// deflection steps down when only the second source moves
	defl_sub_a: assert property (@(posedge clk_i) disable iff (rst_i)
		d_def1 == 2'b00 && d_def2 == 2'b10 && !(wr && adr_i == OFS_DEFL_CNT)
		|=> defl_cnt == $past(defl_cnt) - 16'h0001)
		else $error("deflection did not subtract");
	// bus ack is a single cycle
	bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");

	start_c: cover property (@(posedge clk_i) disable iff (rst_i)
		wr && adr_i == OFS_COMMAND && dat_i[0]);
	hold_c: cover property (@(posedge clk_i) disable iff (rst_i)
		hold ##1 !hold);
	enc_c: cover property (@(posedge clk_i) disable iff (rst_i)
		enc_up ##[1:20] enc_dn);
	rd_c: cover property (@(posedge clk_i) disable iff (rst_i) rd_ack);
endmodule

// ---- dv/axc_quad_src.sv ----
// phase pair model for the encoder or manual pulse generator pins
`timescale 1ns/1ns
module axc_quad_src (
	input  wire logic clk_i,    // reference clock
	input  wire logic rst_i,    // sync reset, high
	input  wire logic go_i,     // one quarter step
	input  wire logic back_i,   // step backwards
	input  wire logic both_i,   // flip both phases at once
	input  wire logic glitch_i, // one-cycle spike on a
	output logic      a_o,      // phase a pin
	output logic      b_o       // phase b pin
);
	logic a; // phase a level
	logic b; // phase b level
	logic g; // spike in flight
	// gray stepping so only one phase moves per step
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			a <= 1'b0;
			b <= 1'b0;
		end else if (both_i) begin
			a <= ~a;
			b <= ~b;
		end else if (go_i) begin
			if ((a == b) ^ back_i)
				a <= ~a;
			else
				b <= ~b;
		end
	end
	// spike too short for the filter to accept
	always_ff @(posedge clk_i) begin
		g <= glitch_i & ~rst_i;
	end
	assign a_o = a ^ g;
	assign b_o = b;
endmodule

// ---- dv/test_axis_counter_input_decoder.sv ----
// self-checking bench for the axis counter front end
`timescale 1ns/1ns
module test_axis_counter_input_decoder import axc_pkg::*; ;
	logic        clk_i = 1'b0;          // reference clock
	logic        rst_i = 1'b1;          // sync reset
	logic        cyc = 1'b0;            // bus cycle and strobe
	logic        we = 1'b0;             // bus write
	logic [7:0]  adr = 8'h00;           // bus address
	logic [31:0] wdat = 32'h0000_0000;  // bus write data
	logic [31:0] rdat;                  // bus read data
	logic        ack;                   // bus ack
	logic [1:0]  go = 2'h0;             // step, bit 0 encoder, bit 1 pulser
	logic [1:0]  bk = 2'h0;             // step backwards
	logic [1:0]  bo = 2'h0;             // flip both phases
	logic [1:0]  gl = 2'h0;             // spike on phase a
	logic [1:0]  pa;                    // phase a pins
	logic [1:0]  pb;                    // phase b pins
	logic        idx = 1'b0;            // index pin
	logic        trig = 1'b0;           // override trigger pin
	logic [2:0]  pz = 3'h0;             // scaled down, scaled up, own pulse
	logic        od = 1'b0;             // own pulse direction
	logic        pu;                    // decoded pulser up
	logic        pd;                    // decoded pulser down
	logic        io;                    // filtered index
	int          nup = 0;               // pulser up pulses seen
	int          ndn = 0;               // pulser down pulses seen
	int          err_total = 0;         // mismatches
	int          n_checks = 0;          // comparisons
	always #5 clk_i = ~clk_i;
	axc_quad_src axc_quad_src_inst [1:0] (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
		.back_i(bk), .both_i(bo), .glitch_i(gl), .a_o(pa), .b_o(pb));
	axc_counter_front axc_counter_front_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
		.stb_i(cyc), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat),
		.ack_o(ack), .enc_phase_a_i(pa[0]), .enc_phase_b_i(pb[0]), .enc_index_i(idx),
		.manual_gen_a_i(pa[1]), .manual_gen_b_i(pb[1]), .override_trigger_input_i(trig),
		.out_pulse_i(pz[0]), .out_dir_i(od), .scaled_up_i(pz[1]), .scaled_dn_i(pz[2]),
		.pulser_up_o(pu), .pulser_dn_o(pd), .enc_index_o(io));
	// tally decoded pulser pulses, each stands one cycle
	always @(posedge clk_i) begin
		nup <= nup + (pu === 1'b1);
		ndn <= ndn + (pd === 1'b1);
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// one classic cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int i;
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		i = 0;
		// ack looked at mid-cycle, where it and the read data are settled
		do begin
			@(negedge clk_i);
			i++;
		end while (ack !== 1'b1 && i < 50);
		if (i == 50)
			err_total++;
		q = rdat;
		@(posedge clk_i);
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0000_0000, q);
		chk(q, e);
	endtask
	// steps spaced wider than the filter window
	task automatic stp(input int k, input int n, input logic back);
		repeat (n) begin
			go[k] <= 1'b1;
			bk[k] <= back;
			@(posedge clk_i);
			go[k] <= 1'b0;
			repeat (5) @(posedge clk_i);
		end
		repeat (8) @(posedge clk_i);
	endtask
	task automatic pls(input int w, input int n);
		repeat (n) begin
			pz[w] <= 1'b1;
			@(posedge clk_i);
			pz[w] <= 1'b0;
			@(posedge clk_i);
		end
		repeat (4) @(posedge clk_i);
	endtask
	// encoder result read from mech counter, pulser result as up and down tallies
	task automatic run(input int k, input logic [31:0] env, input logic g,
		input logic [31:0] e);
		int u0;
		int d0;
		wr(OFS_INPUT_ENV, env);
		wr(OFS_MECH_CNT, 32'h0000_0000);
		u0 = nup;
		d0 = ndn;
		if (g) begin
			gl[k] <= 1'b1;
			@(posedge clk_i);
			gl[k] <= 1'b0;
			repeat (10) @(posedge clk_i);
		end else
			stp(k, 4, 1'b0);
		if (k == 0)
			rc(OFS_MECH_CNT, e);
		else
			chk({nup[15:0] - u0[15:0], ndn[15:0] - d0[15:0]}, e);
	endtask
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// watchdog well beyond the roughly 750 cycles needed
	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		report_and_stop();
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rc(OFS_ERR_CAUSE, 32'h0000_0000);
		rc(OFS_INPUT_ENV, 32'h0000_0000);
		wr(8'hFC, 32'hFFFF_FFFF);
		rc(8'hFC, 32'h0000_0000);
		rc(OFS_POS_CNT, 32'h0000_0000);
		run(0, 32'h0000_0000, 1'b0, 32'h0000_0001);
		run(0, 32'h0010_0000, 1'b0, 32'h0000_0002);
		run(0, 32'h0020_0000, 1'b0, 32'h0000_0004);
		stp(0, 4, 1'b1);
		rc(OFS_MECH_CNT, 32'h0000_0000);
		run(0, 32'h0030_0000, 1'b0, 32'h0000_0000);
		run(0, 32'h0030_0000, 1'b1, 32'h0000_0001);
		run(0, 32'h0034_0000, 1'b1, 32'h0000_0000);
		run(0, 32'h0060_0000, 1'b0, 32'h0FFF_FFFC);
		run(0, 32'h4020_0000, 1'b0, 32'h0000_0000);
		idx <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk({31'h0000_0000, io}, 32'h0000_0001);
		run(1, 32'h0200_0000, 1'b0, 32'h0004_0000);
		run(1, 32'h0600_0000, 1'b0, 32'h0000_0004);
		run(1, 32'h8200_0000, 1'b0, 32'h0000_0000);
		run(1, 32'h0300_0000, 1'b1, 32'h0001_0000);
		run(1, 32'h0308_0000, 1'b1, 32'h0000_0000);
		wr(OFS_INPUT_ENV, 32'h0220_0000);
		bo <= 2'h3;
		@(posedge clk_i);
		bo <= 2'h0;
		repeat (8) @(posedge clk_i);
		rc(OFS_ERR_CAUSE, 32'h0003_0000);
		wr(OFS_ERR_CAUSE, 32'h0003_0000);
		rc(OFS_ERR_CAUSE, 32'h0000_0000);
		wr(OFS_SOURCE_ENV, 32'h0000_0000);
		wr(OFS_CMD_CNT, 32'h0000_0000);
		wr(OFS_DEFL_CNT, 32'h0000_0000);
		wr(OFS_GEN_CNT, 32'h0000_0000);
		wr(OFS_TARGET, 32'h0000_000A);
		wr(OFS_COMMAND, 32'h0000_0001);
		rc(OFS_POS_CNT, 32'h0000_000A);
		pls(0, 3);
		rc(OFS_CMD_CNT, 32'h0000_0003);
		rc(OFS_GEN_CNT, 32'h0000_0003);
		rc(OFS_DEFL_CNT, 32'h0000_0003);
		rc(OFS_POS_CNT, 32'h0000_0007);
		stp(0, 4, 1'b0);
		rc(OFS_DEFL_CNT, 32'h0000_FFFF);
		rc(OFS_CMD_CNT, 32'h0000_0003);
		od <= 1'b1;
		pls(0, 2);
		rc(OFS_CMD_CNT, 32'h0000_0001);
		rc(OFS_POS_CNT, 32'h0000_0005);
		wr(OFS_OPMODE, 32'h0000_4000);
		wr(OFS_COMMAND, 32'h0000_0002);
		pls(0, 2);
		rc(OFS_POS_CNT, 32'h0000_0005);
		trig <= 1'b1;
		repeat (8) @(posedge clk_i);
		pls(0, 1);
		rc(OFS_POS_CNT, 32'h0000_0004);
		wr(OFS_SOURCE_ENV, 32'h0000_0200);
		wr(OFS_MECH_CNT, 32'h0000_0000);
		stp(1, 4, 1'b0);
		pls(1, 3);
		pls(2, 1);
		rc(OFS_MECH_CNT, 32'h0000_0002);
		// half clock over an even 22-edge window, then own pulses on mech and gen
		wr(OFS_SOURCE_ENV, 32'h0000_3100);
		wr(OFS_GEN_CNT, 32'h0000_0000);
		repeat (19) @(posedge clk_i);
		wr(OFS_SOURCE_ENV, 32'h0000_0100);
		od <= 1'b0;
		pls(0, 2);
		rc(OFS_GEN_CNT, 32'h0000_000D);
		rc(OFS_MECH_CNT, 32'h0000_0004);
		report_and_stop();
	end
endmodule
